//--- shared/pis_pkg.sv
// psi5 start-up sequencer constants, register map and carrier types
// assumes a single 125 MHz clock and a plain strobe register port
package pis_pkg;

	// clock rate used to turn microseconds into cycles
	localparam int unsigned PIS_CLK_MHZ = 125;

	// register port
	localparam int PIS_ADDR_W = 8;
	localparam logic [7:0] PIS_REG_CFG_OFS = 8'h00;
	localparam logic [7:0] PIS_REG_STAT_OFS = 8'h04;

	// config register field positions
	localparam int PIS_CFG_MAKER_LSB = 0;
	localparam int PIS_CFG_DEV2_LSB = 8;
	localparam int PIS_CFG_AXIS_LSB = 16;
	localparam int PIS_CFG_RANGE_LSB = 18;
	localparam int PIS_CFG_TEN_BIT = 20;
	localparam int PIS_CFG_SYNC_MODE = 21;
	localparam int PIS_CFG_LOCK = 22;

	// status register field positions
	localparam int PIS_STAT_PHASE_LSB = 0;
	localparam int PIS_STAT_PROG = 3;
	localparam int PIS_STAT_DONE = 4;
	localparam int PIS_STAT_FIELD_LSB = 8;
	localparam int PIS_STAT_REP_LSB = 16;

	// values after reset
	localparam logic PIS_RST_TEN_BIT = 1'b1;
	localparam logic PIS_RST_SYNC_MODE = 1'b0;

	// phase codes shown on the phase output
	localparam logic [1:0] PIS_PH_PROG = 2'h0;
	localparam logic [1:0] PIS_PH_ONE = 2'h1;
	localparam logic [1:0] PIS_PH_TWO = 2'h2;
	localparam logic [1:0] PIS_PH_THREE = 2'h3;

	// transmitted codes
	localparam logic [9:0] PIS_ID10_BASE = 10'h200;
	localparam logic [9:0] PIS_DAT10_BASE = 10'h210;
	localparam logic [9:0] PIS_ID8_BASE = 10'h080;
	localparam logic [9:0] PIS_DAT8_BASE = 10'h084;

	// fixed nibbles
	localparam logic [3:0] PIS_NIB_PROTO = 4'h4;
	localparam logic [3:0] PIS_NIB_BLK_HI = 4'h2;
	localparam logic [3:0] PIS_NIB_BLK_LO = 4'h0;
	localparam logic [3:0] PIS_NIB_TYPE_HI = 4'h0;
	localparam logic [3:0] PIS_NIB_TYPE_LO = 4'h1;
	localparam logic [3:0] PIS_NIB_RANGE_BASE = 4'h7;

	// field counts (last index) and repetition counts
	localparam logic [4:0] PIS_LAST_FIELD10 = 5'h1F;
	localparam logic [4:0] PIS_LAST_FIELD8 = 5'h08;
	localparam logic [4:0] PIS_K10_ASYNC = 5'h08;
	localparam logic [4:0] PIS_K10_SYNC = 5'h04;
	localparam logic [4:0] PIS_K8_ASYNC = 5'h10;
	localparam logic [4:0] PIS_K8_SYNC = 5'h08;

	typedef enum logic [2:0] {
		PIS_SETTLE,
		PIS_OC1,
		PIS_PME,
		PIS_OC2,
		PIS_PHASE2,
		PIS_PROG,
		PIS_DONE
	} pis_state_e;

	typedef struct packed {
		logic lock;
		logic sync_mode;
		logic ten_bit;
		logic [1:0] range;
		logic [1:0] axis;
		logic [7:0] dev_config_two;
		logic [7:0] maker_code_field;
	} pis_cfg_s;

	typedef struct packed {
		logic [9:0] word;
		logic [4:0] field;
		logic valid;
	} pis_tx_s;

endpackage

//--- design/pis_init_sequencer.sv
// psi5 initialization phase 1 and phase 2 sequencer
// assumes SYNC_PIN is asynchronous; register strobes come from CLK logic
`timescale 1ns/1ps

module pis_init_sequencer import pis_pkg::*; #(
	parameter int unsigned SETTLE_US = 1000,
	parameter int unsigned OC1_US = 1000,
	parameter int unsigned PME_US = 2000,
	parameter int unsigned OC2_US = 1000,
	parameter int unsigned ASYNC_PERIOD_US = 228,
	parameter int unsigned PROG_ENTRY_PULSES = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// sync pulses from the receiver
	input wire logic SYNC_PIN,
	// register port
	input wire logic [PIS_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [31:0] RD_DATA,
	// transmission request toward the current modulator
	output logic TX_VALID,
	output logic [9:0] TX_WORD,
	// progress
	output logic [1:0] PHASE,
	output logic PROG_MODE,
	output logic INIT2_DONE
);

	localparam int unsigned SETTLE_CYC = SETTLE_US * PIS_CLK_MHZ;
	localparam int unsigned OC1_CYC = OC1_US * PIS_CLK_MHZ;
	localparam int unsigned PME_CYC = PME_US * PIS_CLK_MHZ;
	localparam int unsigned OC2_CYC = OC2_US * PIS_CLK_MHZ;
	localparam int unsigned ASYNC_CYC = ASYNC_PERIOD_US * PIS_CLK_MHZ;

	typedef struct packed {
		pis_state_e st;
		logic [31:0] tmr;
		logic sync_s1;
		logic sync_s2;
		logic sync_s3;
		logic [7:0] pulses;
		logic entry_seen;
		logic [4:0] field;
		logic half;
		logic [4:0] rep;
		logic slot;
		pis_cfg_s cfg;
		logic [31:0] rd_data;
		pis_tx_s tx;
		logic [1:0] phase;
		logic prog_mode;
		logic init2_done;
	} pis_state_s;

	pis_state_s q, d;
	logic sync_rise;
	logic tick;
	logic [3:0] nib;
	logic [4:0] k_val;
	logic [4:0] last_field;
	logic [1:0] half_bits;
	logic [1:0] half_addr;
	logic [9:0] word;

	function automatic logic [3:0] nibble_of(input logic [4:0] f, input pis_cfg_s c);
		logic [3:0] r;
		r = 4'h0;
		case (f)
			5'd0: r = PIS_NIB_PROTO;
			5'd1: r = PIS_NIB_BLK_HI;
			5'd2: r = PIS_NIB_BLK_LO;
			5'd3: r = c.maker_code_field[7:4];
			5'd4: r = c.maker_code_field[3:0];
			5'd5: r = PIS_NIB_TYPE_HI;
			5'd6: r = PIS_NIB_TYPE_LO;
			5'd7: r = {c.axis, 2'b00};
			5'd8: r = PIS_NIB_RANGE_BASE + {2'b00, c.range};
			5'd9: r = c.dev_config_two[7:4];
			5'd10: r = c.dev_config_two[3:0];
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	always_comb begin
		d = q;
		d.tx.valid = 1'b0;
		// second and third stage only; first stage feeds nothing else
		d.sync_s1 = SYNC_PIN;
		d.sync_s2 = q.sync_s1;
		d.sync_s3 = q.sync_s2;
		sync_rise = q.sync_s2 & ~q.sync_s3;

		k_val = q.cfg.ten_bit ? (q.cfg.sync_mode ? PIS_K10_SYNC : PIS_K10_ASYNC)
			: (q.cfg.sync_mode ? PIS_K8_SYNC : PIS_K8_ASYNC);
		last_field = q.cfg.ten_bit ? PIS_LAST_FIELD10 : PIS_LAST_FIELD8;
		nib = nibble_of(q.field, q.cfg);
		half_bits = q.half ? nib[1:0] : nib[3:2];
		half_addr = {q.field[0], q.half};
		if (q.cfg.ten_bit) begin
			word = q.slot ? (PIS_DAT10_BASE | {6'h00, nib})
				: (PIS_ID10_BASE | {6'h00, q.field[3:0]});
		end else begin
			word = q.slot ? (PIS_DAT8_BASE | {8'h00, half_bits})
				: (PIS_ID8_BASE | {8'h00, half_addr});
		end
		// async mode paces itself; sync mode waits for the receiver
		tick = q.cfg.sync_mode ? sync_rise : (q.tmr == 32'(ASYNC_CYC - 1));

		if (WR_EN && ADDR == PIS_REG_CFG_OFS) begin
			d.cfg.maker_code_field = WR_DATA[PIS_CFG_MAKER_LSB +: 8];
			d.cfg.dev_config_two = WR_DATA[PIS_CFG_DEV2_LSB +: 8];
			d.cfg.axis = WR_DATA[PIS_CFG_AXIS_LSB +: 2];
			d.cfg.range = WR_DATA[PIS_CFG_RANGE_LSB +: 2];
			d.cfg.ten_bit = WR_DATA[PIS_CFG_TEN_BIT];
			d.cfg.sync_mode = WR_DATA[PIS_CFG_SYNC_MODE];
			d.cfg.lock = WR_DATA[PIS_CFG_LOCK];
		end
		if (RD_EN) begin
			d.rd_data = 32'h0000_0000;
			if (ADDR == PIS_REG_CFG_OFS) begin
				d.rd_data[PIS_CFG_MAKER_LSB +: 8] = q.cfg.maker_code_field;
				d.rd_data[PIS_CFG_DEV2_LSB +: 8] = q.cfg.dev_config_two;
				d.rd_data[PIS_CFG_AXIS_LSB +: 2] = q.cfg.axis;
				d.rd_data[PIS_CFG_RANGE_LSB +: 2] = q.cfg.range;
				d.rd_data[PIS_CFG_TEN_BIT] = q.cfg.ten_bit;
				d.rd_data[PIS_CFG_SYNC_MODE] = q.cfg.sync_mode;
				d.rd_data[PIS_CFG_LOCK] = q.cfg.lock;
			end else if (ADDR == PIS_REG_STAT_OFS) begin
				d.rd_data[PIS_STAT_PHASE_LSB +: 2] = q.phase;
				d.rd_data[PIS_STAT_PROG] = q.prog_mode;
				d.rd_data[PIS_STAT_DONE] = q.init2_done;
				d.rd_data[PIS_STAT_FIELD_LSB +: 5] = q.field;
				d.rd_data[PIS_STAT_REP_LSB +: 5] = q.rep;
			end
		end

		case (q.st)
			PIS_SETTLE: begin
				d.tmr = q.tmr + 32'h1;
				if (q.tmr == 32'(SETTLE_CYC - 1)) begin
					d.tmr = 32'h0;
					d.st = PIS_OC1;
				end
			end
			PIS_OC1: begin
				d.tmr = q.tmr + 32'h1;
				if (q.tmr == 32'(OC1_CYC - 1)) begin
					d.tmr = 32'h0;
					d.st = PIS_PME;
				end
			end
			PIS_PME: begin
				d.tmr = q.tmr + 32'h1;
				if (sync_rise && q.pulses != 8'hFF) begin
					d.pulses = q.pulses + 8'h1;
				end
				// a locked part counts pulses but never arms the entry
				if (sync_rise && q.pulses == 8'(PROG_ENTRY_PULSES - 1) && !q.cfg.lock) begin
					d.entry_seen = 1'b1;
				end
				if (q.tmr == 32'(PME_CYC - 1)) begin
					d.tmr = 32'h0;
					d.st = PIS_OC2;
				end
			end
			PIS_OC2: begin
				d.tmr = q.tmr + 32'h1;
				if (q.tmr == 32'(OC2_CYC - 1)) begin
					d.tmr = 32'h0;
					if (q.entry_seen) begin
						d.st = PIS_PROG;
						d.phase = PIS_PH_PROG;
						d.prog_mode = 1'b1;
					end else begin
						d.st = PIS_PHASE2;
						d.phase = PIS_PH_TWO;
					end
				end
			end
			PIS_PHASE2: begin
				d.tmr = q.cfg.sync_mode ? 32'h0 : (tick ? 32'h0 : q.tmr + 32'h1);
				if (tick) begin
					d.tx.valid = 1'b1;
					d.tx.word = word;
					d.tx.field = q.field;
					if (!q.slot) begin
						d.slot = 1'b1;
					end else begin
						d.slot = 1'b0;
						if (q.rep == k_val - 5'h1) begin
							d.rep = 5'h0;
							if (!q.cfg.ten_bit && !q.half) begin
								d.half = 1'b1;
							end else begin
								d.half = 1'b0;
								if (q.field == last_field) begin
									d.st = PIS_DONE;
									d.phase = PIS_PH_THREE;
									d.init2_done = 1'b1;
								end else begin
									d.field = q.field + 5'h1;
								end
							end
						end else begin
							d.rep = q.rep + 5'h1;
						end
					end
				end
			end
			PIS_PROG: begin
				d.prog_mode = 1'b1;
			end
			PIS_DONE: begin
				d.init2_done = 1'b1;
			end
			default: begin
				d.st = PIS_SETTLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			q <= '0;
			q.st <= PIS_SETTLE;
			q.phase <= PIS_PH_ONE;
			q.cfg.ten_bit <= PIS_RST_TEN_BIT;
			q.cfg.sync_mode <= PIS_RST_SYNC_MODE;
		end else begin
			q <= d;
		end
	end

	assign RD_DATA = q.rd_data;
	assign TX_VALID = q.tx.valid;
	assign TX_WORD = q.tx.word;
	assign PHASE = q.phase;
	assign PROG_MODE = q.prog_mode;
	assign INIT2_DONE = q.init2_done;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_phase1_silent: assert property (
		(q.phase == PIS_PH_ONE) |-> !q.tx.valid
	) else $error("transmission during phase 1");

	a_settle_to_oc1: assert property (
		(q.st == PIS_SETTLE && d.st != PIS_SETTLE) |=> (q.st == PIS_OC1 && q.tmr == 32'h0)
	) else $error("settle not followed by first offset cancel");

	a_oc1_to_pme: assert property (
		(q.st == PIS_OC1 && d.st != PIS_OC1) |=> (q.st == PIS_PME && q.tmr == 32'h0)
	) else $error("first offset cancel not followed by entry window");

	a_pme_to_oc2: assert property (
		(q.st == PIS_PME && d.st != PIS_PME) |=> (q.st == PIS_OC2)
	) else $error("entry window not followed by second offset cancel");

	a_lock_blocks: assert property (
		$rose(q.entry_seen) |-> ($past(q.st) == PIS_PME && !$past(q.cfg.lock))
	) else $error("entry armed while locked or outside window");

	a_entry_to_prog: assert property (
		(q.st == PIS_OC2 && d.st != PIS_OC2 && q.entry_seen) |=> (PROG_MODE && PHASE == PIS_PH_PROG)
	) else $error("entry seen but no programming mode");

	a_prog_silent: assert property (
		(q.st == PIS_PROG) |-> !TX_VALID
	) else $error("transmission in programming mode");

	a_auto_phase2: assert property (
		(q.st == PIS_OC2 && d.st != PIS_OC2 && !q.entry_seen) |=> (q.st == PIS_PHASE2 && !PROG_MODE)
	) else $error("phase 2 not entered after phase 1");

	a_sync_paced: assert property (
		(q.st == PIS_PHASE2 && q.cfg.sync_mode && sync_rise) |=> TX_VALID
	) else $error("sync pulse in phase 2 gave no transmission");

	a_id_then_data: assert property (
		(TX_VALID && q.cfg.ten_bit && TX_WORD[9:4] == 6'h20) |->
		(q.slot && TX_WORD[3:0] == q.tx.field[3:0])
	) else $error("identifier slot or field code wrong");

	a_ten_code_range: assert property (
		(TX_VALID && q.cfg.ten_bit) |-> (TX_WORD[9:5] == 5'h10)
	) else $error("10-bit word outside identifier and data codes");

	a_eight_id_code: assert property (
		(TX_VALID && !q.cfg.ten_bit && TX_WORD[9:2] == 8'h20) |-> (TX_WORD[1] == q.tx.field[0])
	) else $error("8-bit identifier does not match field");

	// k read from the rule table, not from k_val, so a bad mux shows up
	a_k_repeat: assert property (
		(q.st == PIS_PHASE2) |-> (q.rep < (q.cfg.ten_bit ? (q.cfg.sync_mode ? 5'h04 : 5'h08)
			: (q.cfg.sync_mode ? 5'h08 : 5'h10)))
	) else $error("repetition count beyond k");

	a_field_step: assert property (
		(q.st == PIS_PHASE2) |=> (q.field == $past(q.field) || q.field == $past(q.field) + 5'h1)
	) else $error("field index skipped or went back");

	a_done_silent: assert property (
		(q.st == PIS_DONE) |=> !TX_VALID
	) else $error("transmission after phase 2 finished");

	a_proto_nibble: assert property (
		(TX_VALID && q.cfg.ten_bit && q.tx.field == 5'h0 && TX_WORD[9:4] == 6'h21) |->
		(TX_WORD == 10'h214)
	) else $error("wrong protocol nibble");

	a_axis_nibble: assert property (
		(TX_VALID && q.cfg.ten_bit && q.tx.field == 5'h7 && TX_WORD[9:4] == 6'h21) |->
		(TX_WORD[3:0] == {q.cfg.axis, 2'b00})
	) else $error("wrong axis nibble");

	a_range_nibble: assert property (
		(TX_VALID && q.cfg.ten_bit && q.tx.field == 5'h8 && TX_WORD[9:4] == 6'h21) |->
		(TX_WORD[3:0] == 4'h7 + {2'b00, q.cfg.range})
	) else $error("wrong range nibble");

	a_last_field: assert property (
		$rose(INIT2_DONE) |-> (TX_VALID && q.tx.field == (q.cfg.ten_bit ? 5'h1F : 5'h08))
	) else $error("phase 2 ended on wrong field");

	c_prog_entry: cover property ($rose(PROG_MODE));
	c_done_ten: cover property ($rose(INIT2_DONE) && q.cfg.ten_bit);
	c_done_eight: cover property ($rose(INIT2_DONE) && !q.cfg.ten_bit);
	c_sync_tx: cover property (TX_VALID && q.cfg.sync_mode);
	c_async_tx: cover property (TX_VALID && !q.cfg.sync_mode);

endmodule

//--- testbench/pis_sync_source.sv
// receiver-side sync pulse source for the start-up sequencer bench
// assumes the bench raises run only while pulses are wanted
`timescale 1ns/1ps

module pis_sync_source #(
	// short enough for eight pulses inside a shortened entry window
	parameter int unsigned GAP = 12
) (
	// clock
	input wire logic clk,
	// control from bench
	input wire logic run,
	// pulse toward the sensor
	output logic sync_pulse
);
	int unsigned cnt = 0;

	initial sync_pulse = 1'b0;

	// one pulse each period; also forms the entry pattern in the window
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 0;
			sync_pulse <= 1'b0;
		end else begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			sync_pulse <= (cnt < 3);
		end
	end
endmodule

//--- testbench/psi5_init_phase_sequencer_tb.sv
// self-checking bench for the start-up sequencer, timers shortened
// assumes one 125 MHz clock and the strobe register port
`timescale 1ns/1ps

module psi5_init_phase_sequencer_tb import pis_pkg::*;;
	logic clk, rst, wr_en, rd_en, src_run, sync_pin, tx_valid, prog_mode, init2_done;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data, d;
	logic [9:0] tx_word;
	logic [1:0] phase;
	logic [9:0] got[$];
	logic [9:0] exp_q[$];
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int t_rel = 0;
	logic [1:0] ph_q;

	pis_init_sequencer #(.SETTLE_US(1), .OC1_US(1), .PME_US(1), .OC2_US(1),
		.ASYNC_PERIOD_US(1)) dut (.CLK(clk), .RST(rst),
		.SYNC_PIN(sync_pin), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
		.RD_EN(rd_en), .RD_DATA(rd_data), .TX_VALID(tx_valid), .TX_WORD(tx_word),
		.PHASE(phase), .PROG_MODE(prog_mode), .INIT2_DONE(init2_done));
	pis_sync_source src (.clk(clk), .run(src_run), .sync_pulse(sync_pin));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// timeout well above the longest case, the async 10-bit run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// nothing may leave during phase 1; phase 1 lasts its four 1 us steps
	always @(posedge clk) begin
		t_rel <= rst ? 0 : t_rel + 1;
		ph_q <= phase;
		if (tx_valid === 1'b1) begin
			got.push_back(tx_word);
			if (phase === PIS_PH_ONE) chk(32'h1, 32'h0);
		end
		if (rst === 1'b0 && ph_q === PIS_PH_ONE && phase !== PIS_PH_ONE)
			chk(32'(t_rel), 32'(4 * PIS_CLK_MHZ));
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		d = rd_data;
	endtask

	function automatic logic [3:0] nib(input logic [31:0] c, input int f);
		case (f)
			0: return PIS_NIB_PROTO;
			1: return PIS_NIB_BLK_HI;
			2: return PIS_NIB_BLK_LO;
			3: return c[7:4];
			4: return c[3:0];
			5: return PIS_NIB_TYPE_HI;
			6: return PIS_NIB_TYPE_LO;
			7: return {c[17:16], 2'b00};
			8: return PIS_NIB_RANGE_BASE + 4'(c[19:18]);
			9: return c[15:12];
			10: return c[11:8];
			default: return 4'h0;
		endcase
	endfunction

	// expected stream: fields ascending, each pair repeated k times
	task automatic build(input logic [31:0] c);
		logic [3:0] n;
		exp_q.delete();
		for (int f = 0; f < (c[20] ? 32 : 9); f++) begin
			n = nib(c, f);
			for (int h = 0; h < (c[20] ? 1 : 2); h++) begin
				for (int r = 0; r < (c[20] ? (c[21] ? 4 : 8) : (c[21] ? 8 : 16)); r++) begin
					if (c[20]) begin
						exp_q.push_back(PIS_ID10_BASE | 10'(f[3:0]));
						exp_q.push_back(PIS_DAT10_BASE | 10'(n));
					end else begin
						exp_q.push_back(PIS_ID8_BASE | 10'({f[0], h[0]}));
						exp_q.push_back(PIS_DAT8_BASE | 10'(h ? n[1:0] : n[3:2]));
					end
				end
			end
		end
	endtask

	task automatic run_case(input logic [31:0] c, input logic pulses, input logic to_prog);
		int w;
		@(posedge clk);
		rst <= 1'b1;
		src_run <= 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		got.delete();
		chk(32'(phase), 32'(PIS_PH_ONE));
		rd(PIS_REG_CFG_OFS);
		chk(d, 32'h0010_0000);
		wr(PIS_REG_CFG_OFS, c);
		wr(8'h08, 32'hFFFF_FFFF);
		rd(PIS_REG_CFG_OFS);
		chk(d, c);
		rd(8'h08);
		chk(d, 32'h0);
		rd(PIS_REG_STAT_OFS);
		chk(d & 32'h1F, 32'h01);
		src_run <= pulses;
		w = 0;
		while (init2_done !== 1'b1 && prog_mode !== 1'b1 && w < 70000) begin
			@(posedge clk);
			w++;
		end
		repeat (60) @(posedge clk);
		rd(PIS_REG_STAT_OFS);
		chk(32'(prog_mode), 32'(to_prog));
		chk(32'(init2_done), 32'(!to_prog));
		if (to_prog) begin
			chk(32'(phase), 32'(PIS_PH_PROG));
			chk(32'(got.size()), 32'h0);
			chk(d & 32'h1F, 32'h08);
		end else begin
			build(c);
			chk(32'(phase), 32'(PIS_PH_THREE));
			chk(d & 32'h1F, 32'h13);
			chk(32'(got.size()), 32'(exp_q.size()));
			for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
				if (c[20])
					chk(32'(got[i]), 32'(exp_q[i]));
				else
					chk(32'(got[i][7:0]), 32'(exp_q[i][7:0]));
			end
		end
		$display("case cfg=%h done, checks=%0d", c, num_checks);
	endtask

	initial begin
		rst = 1'b1;
		src_run = 1'b0;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		run_case(32'h0076_3CA5, 1'b1, 1'b0);
		run_case(32'h0036_3CA5, 1'b1, 1'b1);
		run_case(32'h006D_C35A, 1'b1, 1'b0);
		run_case(32'h0013_7E81, 1'b0, 1'b0);
		tally_and_finish();
	end
endmodule
